// *** hdl/spimc_params.svh ***
// Constants of the serial peripheral master control and status block
//
// Contract
// R1 - With the interrupt enable bit clear the port raises no interrupt and software must poll status.
// R2 - With the interrupt enable bit set an interrupt is requested when transfer done or mode fault is set.
// R3 - The system enable bit hands the shared port pins to the serial function; clearing it returns them to GPIO.
// R4 - With open drain selected the six port outputs only pull low, otherwise they drive both levels.
// R5 - The serial clock rests high with polarity set and low with polarity clear.
// R6 - The rate field divides the processor clock by 2, 4, 16 or 32 for values 00, 01, 10, 11.
// R7 - Transfer done sets at the end of a transfer and clears after a status read then a data access.
// R8 - Write collision sets on a data write during a transfer and clears after a status read then a data access.
// R9 - Mode fault sets when the master sees its slave select low and clears after a status read then a control write; the code needs it as an input.
// R10 - As master, a data write starts a transfer that shifts out and in at once.
// R11 - The phase bit picks the launch and sample clock edges in the usual serial mode way.
`ifndef SPIMC_PARAMS_SVH
`define SPIMC_PARAMS_SVH

// ----------------------------------------
// Register indices (byte address = 4 * index)
// ----------------------------------------
`define SPIMC_IDX_CTRL 8'h28
`define SPIMC_IDX_STAT 8'h29
`define SPIMC_IDX_DATA 8'h2A
`define SPIMC_IDX_IRQ_STAT 8'h2C
`define SPIMC_IDX_IRQ_CLR 8'h2D
`define SPIMC_IDX_IRQ_EN 8'h2E
`define SPIMC_IDX_GPIO 8'h30

// ----------------------------------------
// Fields and reset values
// ----------------------------------------
`define SPIMC_CTRL_RESET 8'h04
`define SPIMC_STAT_DONE 7
`define SPIMC_STAT_COLL 6
`define SPIMC_STAT_FAULT 4
`define SPIMC_GPIO_DIR_LSB 8
`define SPIMC_PIN_SS 5
`define SPIMC_PIN_SCK 4
`define SPIMC_PIN_MOSI 3
`define SPIMC_PIN_MISO 2
`define SPIMC_LAST_EDGE 4'hF

// ----------------------------------------
// Half periods of the serial clock in pclk cycles
// ----------------------------------------
`define SPIMC_HALF_DIV2 5'h01
`define SPIMC_HALF_DIV4 5'h02
`define SPIMC_HALF_DIV16 5'h08
`define SPIMC_HALF_DIV32 5'h10

`endif

// *** hdl/spimc_pkg.sv ***
// Types of the serial peripheral master control and status block
package spimc_pkg;

	typedef struct packed {
		logic irq_en;
		logic sys_en;
		logic open_drain;
		logic master;
		logic cpol;
		logic cpha;
		logic [1:0] rate;
	} spimc_ctrl_type;

	typedef struct packed {
		logic done;
		logic coll;
		logic fault;
	} spimc_flags_type;

	typedef enum logic {st_idle, st_run} spimc_state_type;

endpackage : spimc_pkg

// *** hdl/spimc_top.sv ***
// Serial peripheral master port: APB registers, clock divider, shifter, flags, pins
//
// The register offsets and the APB register port were chosen for this implementation.
`include "spimc_params.svh"

module spimc_top import spimc_pkg::*; #(
	parameter int ADDR_W = 12
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [5:0] port_in,
	output logic [5:0] port_out,
	output logic [5:0] port_oe,
	output logic irq
);

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic is_reg(input logic [ADDR_W-1:0] a, input logic [7:0] idx);
		return a[9:2] == idx;
	endfunction : is_reg

	function automatic logic [4:0] half_cycles(input logic [1:0] rate);
		case (rate)
			2'b00: return `SPIMC_HALF_DIV2;
			2'b01: return `SPIMC_HALF_DIV4;
			2'b10: return `SPIMC_HALF_DIV16;
			default: return `SPIMC_HALF_DIV32;
		endcase
	endfunction : half_cycles

	spimc_ctrl_type ctrl;
	spimc_flags_type flags;
	spimc_flags_type armed;
	spimc_state_type state;
	logic [5:0] gpio_out;
	logic [5:0] gpio_dir;
	logic [2:0] irq_stat;
	logic [2:0] irq_en;
	logic [5:0] pin_meta;
	logic [5:0] pin_sync;
	logic [7:0] shreg;
	logic [7:0] rx_buf;
	logic [4:0] div_cnt;
	logic [3:0] edge_cnt;
	logic [1:0] rate_run;
	logic rx_bit;
	logic mosi_reg;
	logic sck_phase;
	logic [31:0] next_prdata;

	logic access;
	logic wr;
	logic rd;
	logic mapped;
	logic data_acc;
	logic data_wr;
	logic stat_rd;
	logic ctrl_wr;
	logic busy;
	logic tick;
	logic done_pulse;
	logic start;
	logic fault_set;
	logic ss_low;
	logic sck_out;

	assign access = psel & penable;
	assign wr = access & pwrite;
	assign rd = access & ~pwrite;
	assign data_acc = access & is_reg(paddr, `SPIMC_IDX_DATA);
	assign data_wr = data_acc & pwrite;
	assign stat_rd = rd & is_reg(paddr, `SPIMC_IDX_STAT);
	assign ctrl_wr = wr & is_reg(paddr, `SPIMC_IDX_CTRL);
	assign mapped = is_reg(paddr, `SPIMC_IDX_CTRL) | is_reg(paddr, `SPIMC_IDX_STAT)
		| is_reg(paddr, `SPIMC_IDX_DATA) | is_reg(paddr, `SPIMC_IDX_IRQ_STAT)
		| is_reg(paddr, `SPIMC_IDX_IRQ_CLR) | is_reg(paddr, `SPIMC_IDX_IRQ_EN)
		| is_reg(paddr, `SPIMC_IDX_GPIO);
	assign pready = 1'b1;
	assign pslverr = access & ~mapped;

	// ----------------------------------------
	// Pin synchroniser
	// ----------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_meta <= '0;
			pin_sync <= '0;
		end else begin
			pin_meta <= port_in;
			pin_sync <= pin_meta;
		end
	end

	assign ss_low = ~pin_sync[`SPIMC_PIN_SS];

	// ----------------------------------------
	// Software registers
	// ----------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl <= `SPIMC_CTRL_RESET;
			gpio_out <= '0;
			gpio_dir <= '0;
			irq_en <= '0;
		end else if (wr) begin
			if (is_reg(paddr, `SPIMC_IDX_CTRL))
				ctrl <= pwdata[7:0];
			if (is_reg(paddr, `SPIMC_IDX_IRQ_EN))
				irq_en <= pwdata[2:0];
			if (is_reg(paddr, `SPIMC_IDX_GPIO)) begin
				gpio_out <= pwdata[5:0];
				gpio_dir <= pwdata[`SPIMC_GPIO_DIR_LSB+:6];
			end
		end
	end

	// ----------------------------------------
	// Clock divider and shifter
	// ----------------------------------------
	assign busy = (state == st_run);
	assign start = data_wr & ~busy & ctrl.sys_en & ctrl.master; // R10
	assign tick = busy && (div_cnt == half_cycles(rate_run) - 5'h01); // R6
	assign done_pulse = tick && (edge_cnt == `SPIMC_LAST_EDGE);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= st_idle;
			shreg <= '0;
			rx_buf <= '0;
			rx_bit <= 1'b0;
			mosi_reg <= 1'b0;
			sck_phase <= 1'b0;
			div_cnt <= '0;
			edge_cnt <= '0;
			rate_run <= '0;
		end else if (!ctrl.sys_en) begin
			// Disabling the port abandons a transfer in flight
			state <= st_idle;
			sck_phase <= 1'b0;
		end else if (start) begin
			state <= st_run; // R10
			shreg <= pwdata[7:0];
			mosi_reg <= pwdata[7];
			div_cnt <= '0;
			edge_cnt <= '0;
			sck_phase <= 1'b0;
			rate_run <= ctrl.rate; // R6
		end else if (tick) begin
			div_cnt <= '0;
			sck_phase <= ~sck_phase;
			edge_cnt <= edge_cnt + 4'h1;
			if (!edge_cnt[0]) begin
				if (ctrl.cpha)
					mosi_reg <= shreg[7]; // R11
				else
					rx_bit <= pin_sync[`SPIMC_PIN_MISO]; // R11
			end else begin
				shreg <= {shreg[6:0], ctrl.cpha ? pin_sync[`SPIMC_PIN_MISO] : rx_bit}; // R11
				if (!ctrl.cpha)
					mosi_reg <= shreg[6];
				if (edge_cnt == `SPIMC_LAST_EDGE) begin
					state <= st_idle;
					rx_buf <= {shreg[6:0], ctrl.cpha ? pin_sync[`SPIMC_PIN_MISO] : rx_bit};
				end
			end
		end else if (busy) begin
			div_cnt <= div_cnt + 5'h01;
		end
	end

	assign sck_out = ctrl.cpol ^ sck_phase; // R5

	// ----------------------------------------
	// Status flags
	// ----------------------------------------
	// Fault only when slave select is an input; as an output it serves as chip select
	assign fault_set = ctrl.sys_en & ctrl.master & ~gpio_dir[`SPIMC_PIN_SS] & ss_low; // R9

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			flags <= '0;
		end else begin
			flags.done <= done_pulse | (flags.done & ~(data_acc & armed.done)); // R7
			flags.coll <= (data_wr & busy) | (flags.coll & ~(data_acc & armed.coll)); // R8
			flags.fault <= fault_set | (flags.fault & ~(ctrl_wr & armed.fault)); // R9
		end
	end

	// Only flags seen by a status read may be cleared by the following access
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			armed <= '0;
		end else if (stat_rd) begin
			armed <= flags;
		end else begin
			if (data_acc) begin
				armed.done <= 1'b0;
				armed.coll <= 1'b0;
			end
			if (ctrl_wr)
				armed.fault <= 1'b0;
		end
	end

	// ----------------------------------------
	// Interrupt
	// ----------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			irq_stat <= '0;
		else if (wr && is_reg(paddr, `SPIMC_IDX_IRQ_CLR))
			irq_stat <= (irq_stat & ~pwdata[2:0]) | {done_pulse, data_wr & busy, fault_set};
		else
			irq_stat <= irq_stat | {done_pulse, data_wr & busy, fault_set};
	end

	assign irq = ctrl.irq_en & (flags.done | flags.fault | (|(irq_stat & irq_en))); // R1 R2

	// ----------------------------------------
	// Read data, loaded in the setup cycle
	// ----------------------------------------
	always_comb begin
		next_prdata = '0;
		if (is_reg(paddr, `SPIMC_IDX_CTRL))
			next_prdata[7:0] = ctrl;
		if (is_reg(paddr, `SPIMC_IDX_STAT)) begin
			next_prdata[`SPIMC_STAT_DONE] = flags.done;
			next_prdata[`SPIMC_STAT_COLL] = flags.coll;
			next_prdata[`SPIMC_STAT_FAULT] = flags.fault;
		end
		if (is_reg(paddr, `SPIMC_IDX_DATA))
			next_prdata[7:0] = rx_buf;
		if (is_reg(paddr, `SPIMC_IDX_IRQ_STAT))
			next_prdata[2:0] = irq_stat;
		if (is_reg(paddr, `SPIMC_IDX_IRQ_EN))
			next_prdata[2:0] = irq_en;
		if (is_reg(paddr, `SPIMC_IDX_GPIO)) begin
			next_prdata[5:0] = pin_sync;
			next_prdata[`SPIMC_GPIO_DIR_LSB+:6] = gpio_dir;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			prdata <= '0;
		else if (psel && !penable && !pwrite)
			prdata <= next_prdata;
	end

	// ----------------------------------------
	// Port pins
	// ----------------------------------------
	always_comb begin
		logic [5:0] val;
		logic [5:0] drv;
		val = gpio_out;
		drv = gpio_dir;
		if (ctrl.sys_en) begin // R3
			drv[`SPIMC_PIN_MISO] = 1'b0;
			drv[`SPIMC_PIN_SCK] = ctrl.master;
			drv[`SPIMC_PIN_MOSI] = ctrl.master;
			val[`SPIMC_PIN_SCK] = sck_out;
			val[`SPIMC_PIN_MOSI] = mosi_reg;
			if (!ctrl.master)
				drv[`SPIMC_PIN_SS] = 1'b0;
		end
		port_oe = ctrl.open_drain ? (drv & ~val) : drv; // R4
		port_out = ctrl.open_drain ? 6'h00 : val; // R4
	end

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	property p_no_irq_disabled;
		@(posedge pclk) disable iff (!presetn) !ctrl.irq_en |-> !irq;
	endproperty
	a_no_irq_disabled: assert property (p_no_irq_disabled) else $error("irq with enable clear"); // R1

	property p_irq_on_flag;
		@(posedge pclk) disable iff (!presetn) ctrl.irq_en && (flags.done || flags.fault) |-> irq;
	endproperty
	a_irq_on_flag: assert property (p_irq_on_flag) else $error("flag set without irq"); // R2

	property p_gpio_pins;
		@(posedge pclk) disable iff (!presetn) !ctrl.sys_en && !ctrl.open_drain |-> port_oe == gpio_dir;
	endproperty
	a_gpio_pins: assert property (p_gpio_pins) else $error("pins not in gpio use"); // R3

	property p_open_drain;
		@(posedge pclk) disable iff (!presetn) ctrl.open_drain |-> port_out == 6'h00 && (port_oe & gpio_out) == 6'h00
			|| ctrl.sys_en;
	endproperty
	a_open_drain: assert property (p_open_drain) else $error("open drain drives high"); // R4

	property p_sck_idle;
		@(posedge pclk) disable iff (!presetn) !busy && ctrl.sys_en && ctrl.master |-> port_out[`SPIMC_PIN_SCK] == ctrl.cpol
			|| ctrl.open_drain;
	endproperty
	a_sck_idle: assert property (p_sck_idle) else $error("sck not at rest level"); // R5

	property p_rate_div2;
		@(posedge pclk) disable iff (!presetn) $rose(busy) && rate_run == 2'b00 && ctrl.sys_en
			|-> busy [*8] ##1 busy [*8] ##1 !busy;
	endproperty
	a_rate_div2: assert property (p_rate_div2) else $error("div2 transfer length wrong"); // R6

	property p_done_set;
		@(posedge pclk) disable iff (!presetn) done_pulse |=> flags.done && !busy;
	endproperty
	a_done_set: assert property (p_done_set) else $error("done flag missing"); // R7

	property p_done_hold;
		@(posedge pclk) disable iff (!presetn) flags.done && !armed.done |=> flags.done;
	endproperty
	a_done_hold: assert property (p_done_hold) else $error("done cleared without status read"); // R7

	property p_collision;
		@(posedge pclk) disable iff (!presetn) data_wr && busy |=> flags.coll;
	endproperty
	a_collision: assert property (p_collision) else $error("collision not flagged"); // R8

	property p_fault;
		@(posedge pclk) disable iff (!presetn) fault_set |=> flags.fault ##1 (flags.fault || $past(ctrl_wr));
	endproperty
	a_fault: assert property (p_fault) else $error("mode fault not held"); // R9

	property p_start;
		@(posedge pclk) disable iff (!presetn) start |=> busy && edge_cnt == 4'h0;
	endproperty
	a_start: assert property (p_start) else $error("write did not start transfer"); // R10

endmodule : spimc_top

// *** verif/spimc_slave.sv ***
// Behavioural serial slave standing on the far side of the master port
module spimc_slave (
	input wire logic ss_n,
	input wire logic sck,
	input wire logic mosi,
	input wire logic cpol,
	input wire logic cpha,
	input wire logic [7:0] tx_byte,
	output logic miso,
	output logic miso_oe,
	output logic [7:0] rx_byte
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [7:0] sh;
	// Released line is pulled up by the bench, never left at the last bit
	assign miso_oe = !ss_n;
	always @(negedge ss_n) begin
		sh = tx_byte;
		if (!cpha) begin
			miso = sh[7];
			sh = sh << 1;
		end
	end
	always @(sck) begin
		if (!ss_n && ((sck != cpol) ^ cpha)) begin
			rx_byte = {rx_byte[6:0], mosi};
		end else if (!ss_n) begin
			miso = sh[7];
			sh = sh << 1;
		end
	end
endmodule : spimc_slave

// *** verif/spimc_top_tb.sv ***
// Self-checking bench of the serial master control and status block
`include "spimc_params.svh"

module spimc_top_tb;
	timeunit 1ns;
	timeprecision 100ps;
	localparam logic [11:0] A_CTRL = {2'b00, `SPIMC_IDX_CTRL, 2'b00};
	localparam logic [11:0] A_STAT = {2'b00, `SPIMC_IDX_STAT, 2'b00};
	localparam logic [11:0] A_DATA = {2'b00, `SPIMC_IDX_DATA, 2'b00};
	localparam logic [11:0] A_IRQS = {2'b00, `SPIMC_IDX_IRQ_STAT, 2'b00};
	localparam logic [11:0] A_IRQC = {2'b00, `SPIMC_IDX_IRQ_CLR, 2'b00};
	localparam logic [11:0] A_GPIO = {2'b00, `SPIMC_IDX_GPIO, 2'b00};
	localparam logic [11:0] A_IRQE = {2'b00, `SPIMC_IDX_IRQ_EN, 2'b00};
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic [5:0] port_out;
	logic [5:0] port_oe;
	logic [5:0] pin;
	logic irq;
	logic ss_ext = 1'b1;
	logic cpol = 1'b0;
	logic cpha = 1'b0;
	logic [7:0] s_tx = 8'h00;
	logic miso;
	logic miso_oe;
	logic [7:0] s_rx;
	logic [31:0] rd;
	logic er;
	int n_errors = 0;
	int checks = 0;

	// ----------------------------------------
	// Clock, pins with pull-ups, instances
	// ----------------------------------------
	always #4 pclk = ~pclk;
	always_comb begin
		for (int i = 0; i < 6; i++) begin
			pin[i] = port_oe[i] ? port_out[i] : (i == 2 && miso_oe) ? miso : (i == 5) ? ss_ext : 1'b1;
		end
	end
	spimc_top u_spimc_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .port_in(pin),
		.port_out(port_out), .port_oe(port_oe), .irq(irq));
	spimc_slave u_spimc_slave (.ss_n(pin[5]), .sck(pin[4]), .mosi(pin[3]), .cpol(cpol), .cpha(cpha),
		.tx_byte(s_tx), .miso(miso), .miso_oe(miso_oe), .rx_byte(s_rx));

	task automatic test_done();
		$display("checks %0d mismatches %0d", checks, n_errors);
		if (n_errors == 0 && checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : test_done
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checks++;
		if (g !== e) begin
			n_errors++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (pready !== 1'b1) begin
			n_errors++;
			test_done();
		end
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic rc(input logic [11:0] a, input logic [31:0] e, input string nm);
		apb(1'b0, a, 32'h0000_0000);
		chk(nm, e, rd);
	endtask : rc
	// Bounded wait on the interrupt line, sampled away from the launching edge
	task automatic wait_irq(output int n, input logic od);
		n = 0;
		do begin
			@(negedge pclk);
			n++;
			if (od && n == 3) chk("open drain out", 32'h0000_0000, {26'h0, port_out | (port_oe & pin)});
		end while (irq !== 1'b1 && n < 1000);
		if (irq !== 1'b1) begin
			n_errors++;
			test_done();
		end
	endtask : wait_irq

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_reset();
		rc(A_CTRL, 32'h0000_0004, "ctrl reset");
		rc(A_STAT, 32'h0000_0000, "status reset");
		apb(1'b0, 12'h004, 32'h0000_0000);
		chk("unmapped err", 32'h0000_0001, {31'h0, er});
		apb(1'b1, A_CTRL, 32'h0000_0010);
		apb(1'b1, A_DATA, 32'h0000_0055);
		repeat (40) @(negedge pclk);
		rc(A_STAT, 32'h0000_0000, "no transfer when off");
		chk("pins released", 32'h0000_0000, {26'h0, port_oe});
		$display("test reset done");
	endtask : t_reset
	task automatic t_xfer(input logic [1:0] m, input logic [1:0] r, input logic od, input logic [7:0] tx,
		input logic [7:0] sb);
		int n;
		int dv[4] = '{2, 4, 16, 32};
		cpol <= m[1];
		cpha <= m[0];
		s_tx <= sb;
		apb(1'b1, A_GPIO, 32'h0000_3820);
		apb(1'b1, A_CTRL, {24'h0, 2'b11, od, 1'b1, m, r});
		apb(1'b1, A_GPIO, 32'h0000_3800);
		chk("sck rest", {31'h0, m[1]}, {31'h0, pin[4]});
		chk("sck drive", {30'h0, 1'b1, m[1] & ~od}, {30'h0, port_oe[4], port_out[4]});
		apb(1'b1, A_DATA, {24'h0, tx});
		wait_irq(n, od);
		chk("half periods", 32'h0000_0001, {31'h0, n >= 8 * dv[r] && n <= 8 * dv[r] + 3});
		chk("sck rest after", {31'h0, m[1]}, {31'h0, pin[4]});
		apb(1'b0, A_DATA, 32'h0000_0000);
		if (r >= 2) chk("data in", {24'h0, sb}, rd);
		chk("slave got", {24'h0, tx}, {24'h0, s_rx});
		rc(A_STAT, 32'h0000_0080, "done kept");
		apb(1'b0, A_DATA, 32'h0000_0000);
		rc(A_STAT, 32'h0000_0000, "done cleared");
		chk("irq low", 32'h0000_0000, {31'h0, irq});
		apb(1'b1, A_GPIO, 32'h0000_3820);
		@(negedge pclk);
		chk("ss float", {31'h0, ~od}, {31'h0, port_oe[5]});
		$display("test transfer mode %0d done", m);
	endtask : t_xfer
	task automatic t_coll();
		int n;
		apb(1'b1, A_GPIO, 32'h0000_3800);
		apb(1'b1, A_CTRL, 32'h0000_00D1);
		apb(1'b1, A_DATA, 32'h0000_0011);
		apb(1'b1, A_DATA, 32'h0000_0022);
		wait_irq(n, 1'b0);
		rc(A_STAT, 32'h0000_00C0, "collision set");
		apb(1'b1, A_DATA, 32'h0000_0033);
		repeat (40) @(negedge pclk);
		rc(A_STAT, 32'h0000_0080, "collision cleared");
		apb(1'b0, A_DATA, 32'h0000_0000);
		$display("test collision done");
	endtask : t_coll
	task automatic t_fault();
		apb(1'b1, A_IRQC, 32'h0000_0007);
		apb(1'b1, A_GPIO, 32'h0000_1800);
		apb(1'b1, A_CTRL, 32'h0000_00D0);
		ss_ext <= 1'b0;
		repeat (5) @(negedge pclk);
		chk("irq fault", 32'h0000_0001, {31'h0, irq});
		@(posedge pclk);
		ss_ext <= 1'b1;
		apb(1'b1, A_CTRL, 32'h0000_0050);
		repeat (2) @(negedge pclk);
		chk("irq masked", 32'h0000_0000, {31'h0, irq});
		rc(A_STAT, 32'h0000_0010, "fault kept");
		rc(A_IRQS, 32'h0000_0001, "irq status fault");
		apb(1'b1, A_CTRL, 32'h0000_0050);
		rc(A_STAT, 32'h0000_0000, "fault cleared");
		apb(1'b1, A_IRQC, 32'h0000_0001);
		rc(A_IRQS, 32'h0000_0000, "irq status cleared");
		$display("test fault done");
	endtask : t_fault
	task automatic t_irq();
		apb(1'b1, A_IRQE, 32'h0000_0002);
		rc(A_IRQE, 32'h0000_0002, "irq enable readback");
		apb(1'b1, A_CTRL, 32'h0000_00C0);
		apb(1'b1, A_DATA, 32'h0000_0044);
		repeat (40) @(negedge pclk);
		rc(A_STAT, 32'h0000_0000, "no transfer as slave");
		chk("slave pins", 32'h0000_0000, {28'h0, port_oe[5:2]});
		rc(A_GPIO, 32'h0000_183F, "gpio readback");
		apb(1'b1, A_GPIO, 32'h0000_3800);
		apb(1'b1, A_CTRL, 32'h0000_00D1);
		apb(1'b1, A_DATA, 32'h0000_0011);
		apb(1'b1, A_DATA, 32'h0000_0022);
		@(negedge pclk);
		chk("irq from collision", 32'h0000_0001, {31'h0, irq});
		repeat (40) @(negedge pclk);
		rc(A_STAT, 32'h0000_00C0, "both flags set");
		apb(1'b0, A_DATA, 32'h0000_0000);
		rc(A_IRQS, 32'h0000_0006, "irq status sticky");
		chk("irq held by status", 32'h0000_0001, {31'h0, irq});
		apb(1'b1, A_IRQC, 32'h0000_0006);
		@(negedge pclk);
		chk("irq after clear", 32'h0000_0000, {31'h0, irq});
		apb(1'b1, A_IRQE, 32'h0000_0000);
		$display("test irq enable done");
	endtask : t_irq

	initial begin
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		t_reset();
		t_xfer(2'd0, 2'd3, 1'b0, 8'hA5, 8'h3C);
		t_xfer(2'd1, 2'd2, 1'b1, 8'h96, 8'hE1);
		t_xfer(2'd2, 2'd1, 1'b0, 8'h5A, 8'h0F);
		t_xfer(2'd3, 2'd0, 1'b0, 8'hC3, 8'h81);
		t_coll();
		t_fault();
		t_irq();
		test_done();
	end
endmodule : spimc_top_tb
